// ==== design/nsr_host.sv ====
/*
  Host-side status reader for a multi-die flash target: issues plain or addressed status reads,
  optional read-mode return, and reports the status byte over a classic Wishbone slave.
  Assumes the outside world resolves the shared I/O wire from io_oe_o; ready_busy_n_i is asynchronous.
*/
// Functional notes
// RQ1: Each die keeps its own 8-bit status register.
// RQ2: After 70h or 78h the die drives status on every data output request.
// RQ3: Status changes show on the bus while chip select and read strobe stay low.
// RQ4: Host sends 00h to leave status output and resume page data output.
// RQ5: Plain status read answers for the most recently selected die.
// RQ6: Plain status read is accepted by the last-selected die even when busy.
// RQ7: After interleaved multi-die work the host uses the addressed read, never the plain.
// RQ8: On a single-die target the plain read is allowed after any command.
// RQ9: Bit 6 is cache ready; the ready/busy pin follows it.
// RQ10: Bit 5 is array ready, set once all internal work is done.
// RQ11: Bits 4:3 report ECC results on reads, zero on program and erase.
// RQ12: ECC field 11 means a sector needs rewrite.
// RQ13: Bit 1 holds prior program pass/fail, valid when bit 6 is one.
// RQ14: Bit 0 is the last operation fail flag, valid when bit 5 is one.
// RQ15: During page read bit 0 signals an uncorrectable error.
// RQ16: Addressed status read is accepted by every die even when busy.
// RQ17: Addressed read code is followed by row address cycles naming page, block, die.
// RQ18: Dies not named in the row address deselect themselves.
// RQ19: Ready bits are die-wide; fail bits belong to the addressed plane.
// RQ20: After a ready addressed read the host sends 00h before page data output.
// RQ21: No addressed read during power-on reset or while OTP mode is on.
// RQ22: Bit 7 is write-protect status; bit 2 carries no meaning.
`timescale 1ns/1ps
module nsr_host import nsr_pkg::*; (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             ce_n_o,
  output logic             cle_o,
  output logic             ale_o,
  output logic             we_n_o,
  output logic             re_n_o,
  output logic      [7:0]  io_o,
  output logic             io_oe_o,
  input  wire logic [7:0]  io_i,
  input  wire logic        ready_busy_n_i
);
  nsr_regs_t r_q;
  nsr_regs_t r_d;
  logic      bus_req;
  logic      go;
  logic      step_done;

  assign bus_req   = wb_cyc_i && wb_stb_i && !r_q.ack;
  assign go        = bus_req && wb_we_i && wb_adr_i == ADR_CTRL && wb_sel_i[0] && wb_dat_i[CTL_GO];
  assign step_done = r_q.ph && r_q.cnt == CNT_RESET;

  always_comb begin
    r_d       = r_q;
    r_d.ack   = 1'b0;
    r_d.io_s1 = io_i;
    r_d.io_s2 = r_q.io_s1;
    r_d.io_s3 = r_q.io_s2;
    r_d.rb_s1 = ready_busy_n_i;
    r_d.rb_s2 = r_q.rb_s1;
    r_d.rb_s3 = r_q.rb_s2;
    if (bus_req) begin
      r_d.ack = 1'b1;
      if (wb_we_i) begin
        if (wb_adr_i == ADR_CTRL && wb_sel_i[0]) begin
          r_d.cfg = {wb_dat_i[7:1], 1'b0};
        end
        if (wb_adr_i == ADR_ROW && r_q.st == S_IDLE) begin
          if (wb_sel_i[0]) r_d.row[7:0] = wb_dat_i[7:0];
          if (wb_sel_i[1]) r_d.row[15:8] = wb_dat_i[15:8];
          if (wb_sel_i[2]) r_d.row[23:16] = wb_dat_i[23:16];
        end
        if (wb_adr_i == ADR_STAT && wb_sel_i[1]) begin
          if (wb_dat_i[ST_DONE]) r_d.done = 1'b0;
          if (wb_dat_i[ST_REFUSED]) r_d.refused = 1'b0;
        end
      end else begin
        unique case (wb_adr_i)
          ADR_CTRL: r_d.rdat = {24'h000000, r_q.cfg};
          ADR_ROW:  r_d.rdat = {8'h00, r_q.row};
          ADR_STAT: r_d.rdat = {20'h00000, r_q.rb_s3, r_q.refused, r_q.done, r_q.st != S_IDLE, r_q.status};
          default:  r_d.rdat = 32'h00000000;
        endcase
      end
    end
    // Shared write-strobe timing for command and address bytes
    if (r_q.st == S_CMD || r_q.st == S_ADDR || r_q.st == S_RMODE) begin
      if (r_q.cnt != CNT_RESET) begin
        r_d.cnt = r_q.cnt - 8'h01;
      end else if (!r_q.ph) begin
        r_d.ph       = 1'b1;
        r_d.pin.we_n = 1'b1;
        r_d.cnt      = 8'(WE_CYC - 1);
      end
    end
    unique case (r_q.st)
      S_IDLE: begin
        if (go) begin
          if (wb_dat_i[CTL_ENH] && (wb_dat_i[CTL_OTP] || wb_dat_i[CTL_RSTPEND])) begin
            r_d.refused = 1'b1; // RQ21
          end else if (!wb_dat_i[CTL_ENH] && wb_dat_i[CTL_ILV]) begin
            r_d.refused = 1'b1; // RQ7
          end else begin
            r_d.st         = S_CMD;
            r_d.pin.ce_n   = 1'b0;
            r_d.pin.cle    = 1'b1;
            r_d.pin.we_n   = 1'b0;
            r_d.pin.io_oe  = 1'b1;
            r_d.pin.io_out = wb_dat_i[CTL_ENH] ? CMD_STATUS_ENH : CMD_STATUS; // RQ8
            r_d.ph         = 1'b0;
            r_d.idx        = 2'b00;
            r_d.cnt        = 8'(WE_CYC - 1);
          end
        end
      end
      S_CMD: begin
        if (step_done) begin
          r_d.pin.cle = 1'b0;
          if (r_q.cfg[CTL_ENH]) begin
            r_d.st         = S_ADDR; // RQ17
            r_d.pin.ale    = 1'b1;
            r_d.pin.we_n   = 1'b0;
            r_d.pin.io_out = r_q.row[7:0];
            r_d.ph         = 1'b0;
            r_d.cnt        = 8'(WE_CYC - 1);
          end else begin
            r_d.st        = S_WHR;
            r_d.pin.io_oe = 1'b0;
            r_d.cnt       = 8'(WHR_CYC - 1);
          end
        end
      end
      S_ADDR: begin
        if (step_done) begin
          if (r_q.idx == 2'(ROW_CYCLES - 1)) begin
            r_d.st        = S_WHR;
            r_d.pin.ale   = 1'b0;
            r_d.pin.io_oe = 1'b0;
            r_d.cnt       = 8'(WHR_CYC - 1);
          end else begin
            r_d.idx        = r_q.idx + 2'b01;
            r_d.pin.we_n   = 1'b0;
            r_d.pin.io_out = r_q.idx == 2'b00 ? r_q.row[15:8] : r_q.row[23:16]; // RQ17
            r_d.ph         = 1'b0;
            r_d.cnt        = 8'(WE_CYC - 1);
          end
        end
      end
      S_WHR: begin
        if (r_q.cnt != CNT_RESET) begin
          r_d.cnt = r_q.cnt - 8'h01;
        end else begin
          r_d.st       = S_READ;
          r_d.pin.re_n = 1'b0;
          r_d.cnt      = 8'(RE_CYC - 1 + SYNC_CYC);
        end
      end
      S_READ: begin
        if (r_q.cnt != CNT_RESET) begin
          r_d.cnt = r_q.cnt - 8'h01;
        end else if (r_q.io_s2 == r_q.io_s3) begin
          r_d.status = r_q.io_s3;
          // Strobe held low while polling so live status keeps arriving
          if (!(r_q.cfg[CTL_POLL] && !r_q.io_s3[SR_READY])) begin // RQ3
            r_d.pin.re_n = 1'b1;
            if (r_q.cfg[CTL_RDMODE] && r_q.io_s3[SR_READY]) begin
              r_d.st         = S_RMODE; // RQ4 RQ20
              r_d.pin.cle    = 1'b1;
              r_d.pin.we_n   = 1'b0;
              r_d.pin.io_oe  = 1'b1;
              r_d.pin.io_out = CMD_READ_MODE;
              r_d.ph         = 1'b0;
              r_d.cnt        = 8'(WE_CYC - 1);
            end else begin
              r_d.st = S_END;
            end
          end
        end
      end
      S_RMODE: begin
        if (step_done) begin
          r_d.st        = S_END;
          r_d.pin.cle   = 1'b0;
          r_d.pin.io_oe = 1'b0;
        end
      end
      S_END: begin
        r_d.st       = S_IDLE;
        r_d.pin.ce_n = 1'b1;
        r_d.done     = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_q         <= '0;
      r_q.st      <= S_IDLE;
      r_q.cfg     <= CFG_RESET;
      r_q.row     <= ROW_RESET;
      r_q.pin.ce_n <= 1'b1;
      r_q.pin.we_n <= 1'b1;
      r_q.pin.re_n <= 1'b1;
      r_q.rb_s1   <= 1'b1;
      r_q.rb_s2   <= 1'b1;
      r_q.rb_s3   <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  assign wb_dat_o = r_q.rdat;
  assign wb_ack_o = r_q.ack;
  assign ce_n_o   = r_q.pin.ce_n;
  assign cle_o    = r_q.pin.cle;
  assign ale_o    = r_q.pin.ale;
  assign we_n_o   = r_q.pin.we_n;
  assign re_n_o   = r_q.pin.re_n;
  assign io_o     = r_q.pin.io_out;
  assign io_oe_o  = r_q.pin.io_oe;

  enh_guard_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ21
    r_q.st == S_ADDR |-> !(r_q.cfg[CTL_OTP] || r_q.cfg[CTL_RSTPEND]))
    else $error("addressed status read issued during reset or OTP");
  plain_ilv_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ7
    (cle_o && io_oe_o && io_o == CMD_STATUS) |-> !r_q.cfg[CTL_ILV])
    else $error("plain status read while interleaved");
  plain_start_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ8
    (r_q.st == S_IDLE && go && !wb_dat_i[CTL_ENH] && !wb_dat_i[CTL_ILV]) |=> (r_q.st == S_CMD && cle_o && !ce_n_o))
    else $error("plain status read not started");
  row_follow_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ17
    (r_q.st == S_CMD && r_q.cfg[CTL_ENH] && step_done) |=> (r_q.st == S_ADDR && ale_o && io_o == r_q.row[7:0]))
    else $error("row cycles do not follow addressed code");
  rmode_sent_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ20
    (r_q.st == S_READ && r_d.st == S_END) |-> !(r_q.cfg[CTL_RDMODE] && r_q.io_s3[SR_READY]))
    else $error("read mode skipped after ready status");
  rmode_code_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ4
    $rose(r_q.st == S_RMODE) |-> (cle_o && io_oe_o && io_o == CMD_READ_MODE && re_n_o))
    else $error("read mode code wrong");
  poll_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ3
    (r_q.st == S_READ && r_q.cnt == CNT_RESET && r_q.cfg[CTL_POLL] && !r_q.io_s3[SR_READY]) |=> !re_n_o)
    else $error("strobe released while polling busy die");
  no_fight_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(io_oe_o && !re_n_o))
    else $error("host drives bus while die outputs");
  we_width_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(we_n_o) |-> !we_n_o [*5] ##1 we_n_o)
    else $error("write strobe width wrong");
  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
endmodule : nsr_host

// ==== design/nsr_pkg.sv ====
/*
  Package for the die status reader: register map, field positions, command codes, timing and the state record.
  Assumes a 250 MHz clock and an asynchronous flash target on a shared 8-bit bus.
*/
package nsr_pkg;
  localparam int          CLK_MHZ     = 250;
  localparam int          T_STROBE_NS = 20;
  localparam int          T_WHR_NS    = 80;
  localparam int          WE_CYC      = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int          RE_CYC      = WE_CYC;
  localparam int          WHR_CYC     = (T_WHR_NS * CLK_MHZ + 999) / 1000;
  localparam int          SYNC_CYC    = 3;
  localparam int          ROW_CYCLES  = 3;
  localparam logic [7:0]  CMD_STATUS  = 8'h70;
  localparam logic [7:0]  CMD_STATUS_ENH = 8'h78;
  localparam logic [7:0]  CMD_READ_MODE  = 8'h00;
  localparam logic [3:0]  ADR_CTRL    = 4'h0;
  localparam logic [3:0]  ADR_ROW     = 4'h4;
  localparam logic [3:0]  ADR_STAT    = 4'h8;
  localparam int          CTL_GO      = 0;
  localparam int          CTL_ENH     = 1;
  localparam int          CTL_RDMODE  = 2;
  localparam int          CTL_ILV     = 3;
  localparam int          CTL_OTP     = 4;
  localparam int          CTL_RSTPEND = 5;
  localparam int          CTL_POLL    = 6;
  localparam int          ST_BUSY     = 8;
  localparam int          ST_DONE     = 9;
  localparam int          ST_REFUSED  = 10;
  localparam int          ST_RB       = 11;
  localparam int          SR_READY    = 6;
  localparam logic [7:0]  CFG_RESET   = 8'h00;
  localparam logic [23:0] ROW_RESET   = 24'h000000;
  localparam logic [7:0]  CNT_RESET   = 8'h00;

  typedef enum logic [2:0] {S_IDLE, S_CMD, S_ADDR, S_WHR, S_READ, S_RMODE, S_END} nsr_state_t;

  typedef struct packed {
    logic       ce_n;
    logic       cle;
    logic       ale;
    logic       we_n;
    logic       re_n;
    logic [7:0] io_out;
    logic       io_oe;
  } nsr_pins_t;

  typedef struct packed {
    nsr_state_t st;
    logic [7:0] cnt;
    logic       ph;
    logic [1:0] idx;
    logic [7:0] cfg;
    logic [23:0] row;
    logic [7:0] status;
    logic       done;
    logic       refused;
    logic [7:0] io_s1;
    logic [7:0] io_s2;
    logic [7:0] io_s3;
    logic       rb_s1;
    logic       rb_s2;
    logic       rb_s3;
    logic       ack;
    logic [31:0] rdat;
    nsr_pins_t  pin;
  } nsr_regs_t;
endpackage : nsr_pkg

// ==== dv/nsr_die_model.sv ====
/*
  Behavioural two-die flash target that answers plain and addressed status reads.
  Assumes host pins from nsr_host; per-die, per-plane status bytes come from the bench.
*/
`timescale 1ns/1ps
module nsr_die_model #(
  parameter int DIE_BIT   = 18,
  parameter int PLANE_BIT = 6
) (
  input  wire logic            clk_i,
  input  wire logic            ce_n_i,
  input  wire logic            cle_i,
  input  wire logic            ale_i,
  input  wire logic            we_n_i,
  input  wire logic            re_n_i,
  input  wire logic [7:0]      io_i,
  input  wire logic [3:0][7:0] st_i,
  output logic      [7:0]      io_o,
  output logic                 ready_busy_n_o,
  output logic                 rdmode_o
);
  logic        stat_on = 1'b0;
  logic        die     = 1'b0;
  logic        plane   = 1'b0;
  logic [1:0]  acnt    = 2'd0;
  logic [23:0] row     = 24'h000000;
  logic [7:0]  pat     = 8'h5A;
  logic [7:0]  cur;
  initial rdmode_o = 1'b0;
  // Released bus shows a moving pattern
  always @(posedge clk_i) pat <= pat + 8'h01;
  always @(posedge we_n_i) begin
    if (!ce_n_i && cle_i) begin
      stat_on = (io_i == 8'h70);
      rdmode_o = rdmode_o | (io_i == 8'h00);
      acnt = (io_i == 8'h78) ? 2'd3 : 2'd0;
    end else if (!ce_n_i && ale_i && acnt != 2'd0) begin
      row = {io_i, row[23:8]};
      acnt = acnt - 2'd1;
      if (acnt == 2'd0) begin
        die = row[DIE_BIT];
        plane = row[PLANE_BIT];
        stat_on = 1'b1;
      end
    end
  end
  // Ready bits die-wide, others from the addressed plane
  assign cur = {st_i[{die, plane}][7], st_i[{die, 1'b0}][6:5], st_i[{die, plane}][4:0]};
  // Only the selected die drives; live while strobes low
  assign io_o = (!ce_n_i && !re_n_i && stat_on) ? cur : pat;
  assign ready_busy_n_o = st_i[0][6] & st_i[2][6];
endmodule : nsr_die_model

// ==== dv/tb.sv ====
/*
  Self-checking bench for nsr_host against a two-die target model.
  Assumes the shared bus is resolved here from the host's output enable.
*/
`timescale 1ns/1ps
module tb import nsr_pkg::*;;
  logic            clk_i = 1'b0;
  logic            rst_i = 1'b1;
  logic            req   = 1'b0;
  logic            wwe   = 1'b0;
  logic [3:0]      wadr  = 4'h0;
  logic [31:0]     wdat  = 32'h0;
  logic [31:0]     wb_dat_o;
  logic            wb_ack_o, ce_n, cle, ale, we_n, re_n, io_oe, rb_n, rdmode;
  logic [7:0]      host_io, die_io, bus;
  logic [3:0][7:0] st = {4{8'hE0}};
  logic [31:0]     s;
  int              n_mismatch = 0;
  int              n_checks = 0;
  assign bus = io_oe ? host_io : die_io;
  initial forever #2 clk_i = ~clk_i;
  nsr_host i_nsr_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(wwe),
    .wb_adr_i(wadr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .ce_n_o(ce_n), .cle_o(cle), .ale_o(ale), .we_n_o(we_n), .re_n_o(re_n), .io_o(host_io),
    .io_oe_o(io_oe), .io_i(bus), .ready_busy_n_i(rb_n));
  nsr_die_model i_nsr_die_model (.clk_i(clk_i), .ce_n_i(ce_n), .cle_i(cle), .ale_i(ale), .we_n_i(we_n),
    .re_n_i(re_n), .io_i(bus), .st_i(st), .io_o(die_io), .ready_busy_n_o(rb_n), .rdmode_o(rdmode));
  task automatic tally_and_finish();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    req <= 1'b1;
    wwe <= we;
    wadr <= adr;
    wdat <= dat;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    if (n >= 50) begin
      n_mismatch++;
      tally_and_finish();
    end
    req <= 1'b0;
  endtask : wb
  task automatic start(input logic [31:0] ctrl, input logic [23:0] row);
    logic [31:0] d;
    wb(1'b1, ADR_ROW, {8'h00, row}, d);
    wb(1'b1, ADR_CTRL, ctrl, d);
  endtask : start
  task automatic finish(output logic [31:0] r);
    logic [31:0] d;
    int n;
    n = 0;
    do begin
      wb(1'b0, ADR_STAT, 32'h0, r);
      n++;
    end while (r[ST_DONE] !== 1'b1 && r[ST_REFUSED] !== 1'b1 && n < 100);
    if (n >= 100) begin
      n_mismatch++;
      tally_and_finish();
    end
    wb(1'b1, ADR_STAT, 32'h0000_0600, d);
  endtask : finish
  task automatic t_reset();
    wb(1'b0, ADR_STAT, 32'h0, s);
    chk("status", 32'h0000_0800, s);
    wb(1'b0, 4'hC, 32'h0, s);
    chk("unmapped", 32'h0, s);
    wb(1'b0, ADR_CTRL, 32'h0, s);
    chk("ctrl", 32'h0, s);
  endtask : t_reset
  task automatic t_ecc();
    logic [7:0] b;
    for (int e = 0; e < 4; e++) begin
      b = {3'b111, e[1:0], 2'b00, e == 0};
      @(posedge clk_i);
      st[0] <= b;
      start(32'h03, 24'h000000);
      finish(s);
      chk("ecc", {20'h00000, 4'hA, b}, s);
    end
  endtask : t_ecc
  task automatic t_addr();
    @(posedge clk_i);
    st[3] <= 8'h03;
    start(32'h03, 24'h040040);
    finish(s);
    chk("addressed", 32'h0000_0A63, s);
    start(32'h01, 24'h000000);
    finish(s);
    chk("plain", 32'h0000_0A63, s);
  endtask : t_addr
  task automatic t_refuse();
    logic [31:0] c [3] = '{32'h13, 32'h23, 32'h09};
    foreach (c[i]) begin
      start(c[i], 24'h000000);
      finish(s);
      chk("refused", 32'h1, {31'h0, s[ST_REFUSED]});
    end
  endtask : t_refuse
  task automatic t_poll();
    chk("no read mode", 32'h0, {31'h0, rdmode});
    @(posedge clk_i);
    st[2] <= 8'h80;
    start(32'h45, 24'h000000);
    repeat (60) @(posedge clk_i);
    wb(1'b0, ADR_STAT, 32'h0, s);
    chk("busy rb", 32'h1, {30'h0, s[ST_RB], s[ST_BUSY]});
    @(posedge clk_i);
    st[2] <= 8'hE0;
    finish(s);
    chk("poll", 32'h0000_0A63, s);
    chk("read mode", 32'h1, {31'h0, rdmode});
  endtask : t_poll
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_ecc();
    t_addr();
    t_refuse();
    t_poll();
    tally_and_finish();
  end
endmodule : tb
